// [user_io_regs.svh]
// Constants for the welding scanner user I/O block
// Functional notes
// - Diode supply follows diode switch input
// - Fault reset input clears latched fault
// - Fault opens fault output until reset
// - Scan start begins laser output when remote
// - Scan stop halts laser output when remote
// - Guide beam follows input edges
// - Control switching input closed selects remote
// - Start/stop honoured only in remote mode
// - Beam select n picks input unit n
// - Shutter input opens shutter, selects unused
// - Ready closed when diode on and ready
// - Diode-on output closed while diode supplied
// - Monitor end pulses 40 ms after output
// - Monitor normal pulses 40 ms in range
// - Monitor fault pulses 40 ms out of range
// - Acceptance output follows control switch; else ignore
// - Laser indicator closed while light emitted
// - Scan-possible and scanning outputs reflect state
// - Scan-possible open while scanning or card writing
`ifndef USER_IO_REGS_SVH
`define USER_IO_REGS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 25000000
`define PULSE_MS 40
`define PULSE_CYCLES ((`CLK_HZ / 1000) * `PULSE_MS)
`define DEBOUNCE_CYCLES 250
// ----------------------------------------
// Input vector bit positions
// ----------------------------------------
`define IN_DIODE 0
`define IN_RESET 1
`define IN_START 2
`define IN_STOP 3
`define IN_GUIDE 4
`define IN_REMOTE 5
`define IN_SHUTTER 6
`define IN_SEL1 7
`define IN_SEL2 8
`define IN_SEL3 9
`define IN_COUNT 10
`endif

// [user_io_pkg.sv]
// Types shared by the welding scanner user I/O block
package user_io_pkg;
  typedef struct packed {
    logic shutter_open;
    logic [2:0] beam_select;
    logic guide_beam;
  } beam_ctrl_t;
  typedef struct packed {
    logic monitor_end;
    logic monitor_normal;
    logic monitor_fault;
  } monitor_pulse_t;
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN = 2'b01
  } scan_state_t;
endpackage

// [welding_scanner_user_io.sv]
// Discrete user contact I/O logic of the welding scanner controller
`timescale 1ns/100ps
`include "user_io_regs.svh"
module welding_scanner_user_io #(
  parameter int PULSE_CYCLES = `PULSE_CYCLES,
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [`IN_COUNT-1:0] i_contacts,
  input wire logic i_sw_remote,
  input wire logic i_shutter_mode,
  input wire logic i_laser_ready,
  input wire logic i_fault_event,
  input wire logic i_laser_emitting,
  input wire logic i_output_done,
  input wire logic i_energy_valid,
  input wire logic i_energy_in_range,
  input wire logic i_card_writing,
  input wire logic i_scan_done,
  output logic o_diode_supply,
  output logic o_ready,
  output logic o_diode_supplied_output,
  output logic o_fault_ok,
  output user_io_pkg::monitor_pulse_t o_monitor,
  output logic o_input_accept,
  output logic o_laser_indicator,
  output logic o_scanning,
  output logic o_scan_possible_output,
  output logic o_scan_start_pulse,
  output logic o_scan_stop_pulse,
  output user_io_pkg::beam_ctrl_t o_beam
);
  import user_io_pkg::*;

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  // Conditioned contact levels and their edges
  logic [`IN_COUNT-1:0] sync1_reg;
  logic [`IN_COUNT-1:0] sync2_reg;
  logic [`IN_COUNT-1:0] clean_reg;
  logic [`IN_COUNT-1:0] clean_prev_reg;
  logic [`IN_COUNT-1:0] rise;
  logic [`IN_COUNT-1:0] fall;

  // Two-stage synchroniser on every contact
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (i_clk_en) begin
      sync1_reg <= i_contacts;
      sync2_reg <= sync1_reg;
    end
  end

  // Per-input debounce: level must hold steady for the full count
  genvar gi;
  generate
    for (gi = 0; gi < `IN_COUNT; gi++) begin : g_deb
      logic [15:0] cnt_reg;
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          cnt_reg <= 16'h0000;
          clean_reg[gi] <= 1'b0;
        end else if (i_clk_en) begin
          if (sync2_reg[gi] == clean_reg[gi]) begin
            cnt_reg <= 16'h0000;
          end else if (cnt_reg >= 16'(DEBOUNCE_CYCLES - 1)) begin
            cnt_reg <= 16'h0000;
            clean_reg[gi] <= sync2_reg[gi];
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // Previous clean level for edge decisions
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      clean_prev_reg <= '0;
    end else if (i_clk_en) begin
      clean_prev_reg <= clean_reg;
    end
  end

  // Edge flags from the clean levels
  assign rise = clean_reg & ~clean_prev_reg;
  assign fall = ~clean_reg & clean_prev_reg;

  // ----------------------------------------
  // Mode and command decoding
  // ----------------------------------------
  // Mode and command terms
  logic ext_ok;
  logic remote;
  logic start_cmd;
  logic stop_cmd;

  // Remote from the contact or the host; commands need remote
  assign ext_ok = clean_reg[`IN_REMOTE];
  assign remote = ext_ok | i_sw_remote;
  assign start_cmd = remote & rise[`IN_START];
  assign stop_cmd = remote & rise[`IN_STOP];

  // ----------------------------------------
  // Diode supply and fault latch
  // ----------------------------------------
  logic fault_reg;

  // Diode follows switch input while external inputs are accepted
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_diode_supply <= 1'b0;
    end else if (i_clk_en) begin
      if (ext_ok) begin
        o_diode_supply <= clean_reg[`IN_DIODE];
      end
    end
  end

  // Diode-on contact, one cycle behind the supply command
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_diode_supplied_output <= 1'b0;
    end else if (i_clk_en) begin
      o_diode_supplied_output <= o_diode_supply;
    end
  end

  // Ready contact: diode on and laser able to emit
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
    end else if (i_clk_en) begin
      o_ready <= o_diode_supply & i_laser_ready;
    end
  end

  // Fault latch; a new fault wins over a reset in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (i_fault_event) begin
        fault_reg <= 1'b1;
      end else if (ext_ok && clean_reg[`IN_RESET]) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // Fault contact opens on the event itself, not a cycle later
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_fault_ok <= 1'b0;
    end else if (i_clk_en) begin
      o_fault_ok <= ~(fault_reg | i_fault_event);
    end
  end

  // ----------------------------------------
  // Scan control
  // ----------------------------------------
  scan_state_t scan_reg;

  // Start enters run, stop or completion returns to idle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scan_reg <= SCAN_IDLE;
    end else if (i_clk_en) begin
      case (scan_reg)
        SCAN_IDLE: begin
          if (start_cmd && o_scan_possible_output) begin
            scan_reg <= SCAN_RUN;
          end
        end
        SCAN_RUN: begin
          if (stop_cmd) begin
            scan_reg <= SCAN_IDLE;
          end else if (i_scan_done) begin
            scan_reg <= SCAN_IDLE;
          end
        end
        default: scan_reg <= SCAN_IDLE;
      endcase
    end
  end

  // One-cycle strobes for a scan started or stopped by input
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_scan_start_pulse <= 1'b0;
      o_scan_stop_pulse <= 1'b0;
    end else if (i_clk_en) begin
      o_scan_start_pulse <= (scan_reg == SCAN_IDLE) & start_cmd
                            & o_scan_possible_output;
      o_scan_stop_pulse <= (scan_reg == SCAN_RUN) & stop_cmd;
    end
  end

  // ----------------------------------------
  // Status contacts
  // ----------------------------------------
  // Scanning contact closed for the whole scan
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_scanning <= 1'b0;
    end else if (i_clk_en) begin
      o_scanning <= (scan_reg == SCAN_RUN);
    end
  end

  // Scan possible only when ready, idle, no card write and no fault
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_scan_possible_output <= 1'b0;
    end else if (i_clk_en) begin
      o_scan_possible_output <= o_ready & (scan_reg == SCAN_IDLE)
                                & ~i_card_writing & ~fault_reg;
    end
  end

  // Acceptance contact mirrors the control switching input
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_input_accept <= 1'b0;
    end else if (i_clk_en) begin
      o_input_accept <= ext_ok;
    end
  end

  // Laser indicator copy, for display only
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_laser_indicator <= 1'b0;
    end else if (i_clk_en) begin
      o_laser_indicator <= i_laser_emitting;
    end
  end

  // ----------------------------------------
  // Beam controls
  // ----------------------------------------
  // Guide on edges; shutter or select by configuration
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_beam <= '0;
    end else if (i_clk_en) begin
      if (ext_ok && rise[`IN_GUIDE]) begin
        o_beam.guide_beam <= 1'b1;
      end else if (ext_ok && fall[`IN_GUIDE]) begin
        o_beam.guide_beam <= 1'b0;
      end
      if (ext_ok) begin
        if (i_shutter_mode) begin
          o_beam.shutter_open <= clean_reg[`IN_SHUTTER];
          o_beam.beam_select <= 3'h0;
        end else begin
          o_beam.shutter_open <= 1'b0;
          o_beam.beam_select <= clean_reg[`IN_SEL3:`IN_SEL1];
        end
      end
    end
  end

  // ----------------------------------------
  // Monitor pulses, 40 ms each, retriggerable
  // ----------------------------------------
  // Monitor triggers and pulse levels
  logic [2:0] trig;
  logic [2:0] pulse_q;
  // One trigger per monitor contact
  assign trig = {i_output_done,
                 i_energy_valid & i_energy_in_range,
                 i_energy_valid & ~i_energy_in_range};

  generate
    for (gi = 0; gi < 3; gi++) begin : g_mon
      logic [23:0] pcnt_reg;
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          pcnt_reg <= 24'h000000;
          pulse_q[gi] <= 1'b0;
        end else if (i_clk_en) begin
          if (trig[gi]) begin
            pcnt_reg <= 24'(PULSE_CYCLES - 1);
            pulse_q[gi] <= 1'b1;
          end else if (pcnt_reg != 24'h000000) begin
            pcnt_reg <= pcnt_reg - 24'h000001;
          end else begin
            pulse_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Monitor contacts
  // ----------------------------------------
  // Pulse flops drive the contacts directly
  assign o_monitor = {pulse_q[2], pulse_q[1], pulse_q[0]};
endmodule // welding_scanner_user_io

// [user_io_monitor.sv]
// Assertion checker for the welding scanner user I/O block
`timescale 1ns/100ps
`include "user_io_regs.svh"
module user_io_monitor #(parameter int PULSE_CYCLES = `PULSE_CYCLES) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [`IN_COUNT-1:0] i_contacts,
  input wire logic i_fault_event,
  input wire logic i_output_done,
  input wire logic i_energy_valid,
  input wire logic i_energy_in_range,
  input wire logic i_card_writing,
  input wire logic o_diode_supply,
  input wire logic o_diode_supplied_output,
  input wire logic o_fault_ok,
  input wire user_io_pkg::monitor_pulse_t o_monitor,
  input wire logic o_input_accept,
  input wire logic o_scanning,
  input wire logic o_scan_possible_output,
  input wire logic o_scan_start_pulse,
  input wire logic o_scan_stop_pulse
);
  import user_io_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || !i_clk_en);
  int cnt;
  // Length of the end pulse, cleared on retrigger, held while frozen
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en) begin
      cnt <= (o_monitor.monitor_end && !i_output_done) ? cnt + 1 : 0;
    end
  end
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  property p_sup; $rose(o_diode_supply) |=> o_diode_supplied_output; endproperty
  a_sup: assert property (p_sup) else $error("diode-on output lags");
  property p_flt; i_fault_event |-> ##[1:2] !o_fault_ok; endproperty
  a_flt: assert property (p_flt) else $error("fault not shown");
  property p_end; i_output_done |=> o_monitor.monitor_end [*8]; endproperty
  a_end: assert property (p_end) else $error("end pulse missing");
  property p_nrm;
    i_energy_valid && i_energy_in_range |=> o_monitor.monitor_normal [*4];
  endproperty
  a_nrm: assert property (p_nrm) else $error("in-range verdict missing");
  property p_bad;
    i_energy_valid && !i_energy_in_range |=> o_monitor.monitor_fault [*4];
  endproperty
  a_bad: assert property (p_bad) else $error("out-of-range verdict missing");
  property p_sta; o_scan_start_pulse |=> o_scanning; endproperty
  a_sta: assert property (p_sta) else $error("start strobe without scan");
  property p_stp; o_scan_stop_pulse |=> !o_scanning; endproperty
  a_stp: assert property (p_stp) else $error("stop strobe with scan");
  property p_len; cnt <= PULSE_CYCLES + 2; endproperty
  a_len: assert property (p_len) else $error("pulse too long");
  property p_acc;
    $rose(o_input_accept) |-> $past(i_contacts[`IN_REMOTE], 2) && $past(i_contacts[`IN_REMOTE], 3);
  endproperty
  a_acc: assert property (p_acc) else $error("accept without input");
  property p_crd; i_card_writing |=> !o_scan_possible_output; endproperty
  a_crd: assert property (p_crd) else $error("scan possible while writing");
  property p_run; !(o_scanning && o_scan_possible_output); endproperty
  a_run: assert property (p_run) else $error("scan possible while scanning");
endmodule // user_io_monitor
bind welding_scanner_user_io user_io_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) user_io_monitor_i (
  .i_sys_clk, .i_rst_n, .i_clk_en, .i_contacts, .i_fault_event, .i_output_done, .i_energy_valid,
  .i_energy_in_range, .i_card_writing, .o_diode_supply, .o_diode_supplied_output, .o_fault_ok,
  .o_monitor, .o_input_accept, .o_scanning, .o_scan_possible_output, .o_scan_start_pulse,
  .o_scan_stop_pulse);

// [user_device_model.sv]
// Model of the user device that closes the contact inputs
`timescale 1ns/100ps
module user_device_model (
  output logic [9:0] o_contacts
);
  initial o_contacts = '0;
  // Sets one contact; the laser indicator is never used for timing
  task automatic put(input int n, input logic v);
    o_contacts[n] = v;
  endtask
endmodule // user_device_model

// [tb_top.sv]
// Self-checking bench for the welding scanner user I/O block
`timescale 1ns/100ps
`include "user_io_regs.svh"
module tb_top;
  import user_io_pkg::*;
  localparam int PC = 20;
  logic i_sys_clk = 0, i_rst_n = 0, i_clk_en = 1, i_sw_remote = 0, i_shutter_mode = 0;
  logic i_laser_ready = 1, i_fault_event = 0, i_laser_emitting = 0, i_output_done = 0;
  logic i_energy_valid = 0, i_energy_in_range = 0, i_card_writing = 0, i_scan_done = 0;
  logic [`IN_COUNT-1:0] i_contacts;
  logic o_diode_supply, o_ready, o_diode_supplied_output, o_fault_ok, o_input_accept;
  logic o_laser_indicator, o_scanning, o_scan_possible_output;
  monitor_pulse_t o_monitor;
  beam_ctrl_t o_beam;
  int fails = 0, n_tests = 0, seed = 68589, w;
  user_device_model user_device_model_i (.o_contacts(i_contacts));
  welding_scanner_user_io #(.PULSE_CYCLES(PC), .DEBOUNCE_CYCLES(3)) welding_scanner_user_io_i (
    .i_sys_clk, .i_rst_n, .i_clk_en, .i_contacts, .i_sw_remote, .i_shutter_mode, .i_laser_ready,
    .i_fault_event, .i_laser_emitting, .i_output_done, .i_energy_valid, .i_energy_in_range,
    .i_card_writing, .i_scan_done, .o_diode_supply, .o_ready, .o_diode_supplied_output,
    .o_fault_ok, .o_monitor, .o_input_accept, .o_laser_indicator, .o_scanning,
    .o_scan_possible_output, .o_scan_start_pulse(), .o_scan_stop_pulse(), .o_beam);
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected monitor code for one energy verdict
  function automatic monitor_pulse_t exp_mon(input logic in_range);
    monitor_pulse_t m;
    m = '0;
    m.monitor_normal = in_range;
    m.monitor_fault = !in_range;
    return m;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Contact change, then time for sync and debounce
  task automatic put(input int n, input logic v);
    user_device_model_i.put(n, v);
    cyc(10);
  endtask
  task automatic hit(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  // Counts cycles the monitor pulse stays up
  task automatic span;
    w = 0;
    while (o_monitor != 0 && w < 99) begin
      w++;
      cyc(1);
    end
  endtask
  initial forever #20 i_sys_clk = ~i_sys_clk;
  initial begin
    #200000;
    fails++;
    final_report;
  end
  initial begin
    cyc(3);
    i_rst_n = 1;
    cyc(2);
    put(`IN_DIODE, 1);
    put(`IN_START, 1);
    chk(o_diode_supply, 0);
    chk(o_scanning, 0);
    put(`IN_START, 0);
    put(`IN_REMOTE, 1);
    chk(o_input_accept, 1);
    chk(o_diode_supply, 1);
    chk(o_diode_supplied_output, 1);
    chk(o_ready, 1);
    put(`IN_START, 1);
    chk(o_scanning, 1);
    chk(o_scan_possible_output, 0);
    put(`IN_STOP, 1);
    chk(o_scanning, 0);
    put(`IN_START, 0);
    put(`IN_STOP, 0);
    chk(o_scan_possible_output, 1);
    hit(i_card_writing);
    chk(o_scan_possible_output, 0);
    put(`IN_START, 1);
    hit(i_scan_done);
    cyc(2);
    chk(o_scanning, 0);
    put(`IN_START, 0);
    user_device_model_i.put(`IN_GUIDE, 1);
    cyc(1);
    put(`IN_GUIDE, 0);
    chk(o_beam.guide_beam, 0);
    put(`IN_GUIDE, 1);
    chk(o_beam.guide_beam, 1);
    for (int n = 0; n < 3; n++) begin
      put(`IN_SEL1 + n, 1);
      chk(o_beam.beam_select, 3'h1 << n);
      put(`IN_SEL1 + n, 0);
    end
    i_shutter_mode = 1;
    put(`IN_SHUTTER, 1);
    chk(o_beam.shutter_open, 1);
    chk(o_beam.beam_select, 3'h0);
    hit(i_fault_event);
    cyc(20);
    chk(o_fault_ok, 0);
    put(`IN_RESET, 1);
    chk(o_fault_ok, 1);
    put(`IN_RESET, 0);
    put(`IN_REMOTE, 0);
    i_sw_remote = 1;
    put(`IN_START, 1);
    chk(o_scanning, 1);
    // Span starts one cycle into each pulse, so that cycle is added back
    repeat (4) begin
      i_energy_in_range = 1'($random(seed));
      i_laser_emitting = 1'($random(seed));
      hit(i_energy_valid);
      chk(o_laser_indicator, i_laser_emitting);
      cyc(1);
      chk(o_monitor, exp_mon(i_energy_in_range));
      span;
      chk(w + 1, PC);
    end
    hit(i_output_done);
    cyc(8);
    hit(i_output_done);
    cyc(1);
    span;
    chk(w + 1, PC);
    // Frozen clock enable: a stop must wait until the enable returns
    i_clk_en = 0;
    put(`IN_STOP, 1);
    chk(o_scanning, 1);
    i_clk_en = 1;
    cyc(10);
    chk(o_scanning, 0);
    final_report;
  end
endmodule // tb_top
